/* dxm_ext_mode_config.sv */
// Extended mode register bank of the DDR2 device with AXI4-Lite view
//
// Overview of operation
// - Settings captured on load and held until next load or power loss.
// - Bit 0 of the first register turns the delay-locked loop on or off.
// - Self refresh stops the DLL; exit restarts and resets it.
// - Bit 1 chooses full or reduced output drive strength.
// - Bit 10 clear drives complementary strobe; set makes strobe single.
// - Complementary redundant strobe only with bit 11 set, bit 10 clear.
// - x8 with bit 11: redundant strobe mirrors strobe on reads only.
// - Bit 12 set disables data and strobe outputs.
// - Bits 6 and 2 choose termination off, 75, 150 or 50 ohm.
// - Termination pin honoured only in active and power-down states.
// - Bits 3 to 5 give additive latency 0 to 6 clocks.
// - Reads and writes held internally for the additive latency.
// - Read latency is additive plus CAS; write latency one less.
// - Second register acts only on bit 7; others stored but reserved.
// - Load with bank address 0 high, 1 low targets first register.
// - Load with bank address 0 low, 1 high targets second register.
// - CAS latency counted in whole clocks from the internal read.
`include "dxm_defs.svh"
module dxm_ext_mode_config (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  dxm_pkg::dxm_axil_req_t  axi_req,
  output dxm_pkg::dxm_axil_resp_t axi_resp,
  input  dxm_pkg::dxm_cmd_pins_t  pins,
  output dxm_pkg::dxm_cfg_out_t   cfg
);
  localparam int PINS_W = $bits(dxm_pkg::dxm_cmd_pins_t);
  typedef struct packed {
    logic                  cke_q;
    dxm_pkg::dxm_pwr_t     pwr;
    logic [12:0]           emr_pend;
    logic [12:0]           ext_mode_register_second_pend;
    logic                  pend_emr;
    logic                  pend_ext_mode_register_second;
    logic [1:0]            mrd_cnt;
    logic [12:0]           emr_cur;
    logic [12:0]           ext_mode_register_second_cur;
    logic [7:0]            lock_cnt;
    logic                  dll_locked;
    logic [3:0]            odt_cnt;
    logic [6:0]            rd_q;
    logic [6:0]            wr_q;
    logic [2:0]            cl;
    logic                  x8;
    logic                  odt_early;
    logic                  rsvd_err;
    dxm_pkg::dxm_cfg_out_t out;
  } dxm_state_t;

  dxm_state_t             s_r;
  dxm_state_t             s_nxt;
  dxm_pkg::dxm_cmd_pins_t p;
  logic                   wr_en;
  logic [7:0]             wr_addr;
  logic [31:0]            wr_data;
  logic [3:0]             wr_strb;
  logic [2:0]             wr_dec;
  logic [2:0]             rd_dec;
  logic [31:0]            rd_data;
  logic                   active;
  logic                   lm_any;
  logic                   lm_emr;
  logic                   lm_ext_mode_register_second;
  logic                   lm_mr_dll;
  logic                   rd_cmd;
  logic                   wr_cmd;
  logic                   sr_enter;
  logic                   pd_enter;
  logic                   wake;
  logic [12:0]            lm_addr;
  logic                   rsvd_upper;
  logic                   apply;
  logic [2:0]             cur_al;
  logic                   rtt_on;
  logic                   dll_on;
  logic                   int_rd;
  logic                   int_wr;
  logic                   rsvd_hit;
  logic                   odt_bad;

  // Returns {hit, index}; shared by read and write decode
  function automatic logic [2:0] reg_decode(input logic [7:0] a);
    logic [2:0] r;
    case (a)
      `DXM_REG_CTRL:   r = 3'h4;
      `DXM_REG_EMR:    r = 3'h5;
      `DXM_REG_EXT_MODE_REGISTER_SECOND:   r = 3'h6;
      `DXM_REG_STATUS: r = 3'h7;
      default:         r = 3'h0;
    endcase
    return r;
  endfunction

  dxm_pin_sync #(
    .W   (PINS_W),
    .RST (`DXM_PINS_RST)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (pins),
    .dout    (p)
  );
  dxm_axil_slave u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .req     (axi_req),
    .resp    (axi_resp),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_dec[2]),
    .rd_data (rd_data),
    .rd_ok   (rd_dec[2])
  );
  assign wr_dec = reg_decode(wr_addr);
  assign rd_dec = reg_decode(axi_req.araddr);
  assign active = s_r.pwr == dxm_pkg::DXM_ACTIVE;
  // loads only taken in active state
  assign lm_any = active && p.cke && !p.cs_n && !p.ras_n && !p.cas_n &&
                  !p.we_n;
  assign lm_emr = lm_any && (p.ba[1:0] == `DXM_BA_EMR);
  assign lm_ext_mode_register_second = lm_any && (p.ba[1:0] == `DXM_BA_EXT_MODE_REGISTER_SECOND);
  // DLL reset through main register load
  assign lm_mr_dll = lm_any && (p.ba[1:0] == `DXM_BA_MR) &&
                     p.addr[`DXM_MR_DLL_RST];
  assign rd_cmd = active && p.cke && !p.cs_n && p.ras_n && !p.cas_n &&
                  p.we_n;
  assign wr_cmd = active && p.cke && !p.cs_n && p.ras_n && !p.cas_n &&
                  !p.we_n;
  assign sr_enter = active && s_r.cke_q && !p.cke && !p.cs_n &&
                    !p.ras_n && !p.cas_n && p.we_n;
  assign pd_enter = active && s_r.cke_q && !p.cke && !sr_enter;
  assign wake = !active && p.cke;
  assign lm_addr = p.addr[12:0];
  assign rsvd_upper = p.ba[2] || (p.addr[15:13] != 3'h0);
  assign apply = s_r.mrd_cnt == 2'h1;
  assign cur_al = s_r.emr_cur[`DXM_E_AL_LSB +: 3];
  assign rtt_on = s_r.emr_cur[`DXM_E_RTT_HI] || s_r.emr_cur[`DXM_E_RTT_LO];
  // DLL follows bit 0 and stops in self refresh
  assign dll_on = !s_r.emr_cur[`DXM_E_DLL_OFF] &&
                  (s_r.pwr != dxm_pkg::DXM_SELF_REFRESH);
  assign int_rd = (cur_al == 3'h0) ? rd_cmd : s_r.rd_q[3'(cur_al - 3'h1)];
  assign int_wr = (cur_al == 3'h0) ? wr_cmd : s_r.wr_q[3'(cur_al - 3'h1)];
  // termination pin high before the hold ends
  assign odt_bad = p.odt && (s_r.odt_cnt != 4'h0);

  always_comb begin
    case (rd_dec[1:0])
      2'h0: rd_data = {28'h0, s_r.x8, s_r.cl};
      2'h1: rd_data = {19'h0, s_r.emr_cur};
      2'h2: rd_data = {19'h0, s_r.ext_mode_register_second_cur};
      default: rd_data = {22'h0, s_r.rsvd_err, s_r.odt_early, 3'h0,
                          s_r.out.term_on, s_r.out.settings_pending,
                          s_r.pwr == dxm_pkg::DXM_SELF_REFRESH,
                          s_r.dll_locked, dll_on};
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    rsvd_hit = 1'b0;
    s_nxt.cke_q = p.cke;
    // Power state decides which pins the device honours
    case (s_r.pwr)
      dxm_pkg::DXM_ACTIVE: begin
        if (sr_enter) begin
          s_nxt.pwr = dxm_pkg::DXM_SELF_REFRESH;
        end else if (pd_enter) begin
          s_nxt.pwr = dxm_pkg::DXM_POWER_DOWN;
        end
      end
      dxm_pkg::DXM_POWER_DOWN: begin
        if (wake) begin
          s_nxt.pwr = dxm_pkg::DXM_ACTIVE;
        end
      end
      dxm_pkg::DXM_SELF_REFRESH: begin
        if (wake) begin
          s_nxt.pwr = dxm_pkg::DXM_ACTIVE;
        end
      end
      default: s_nxt.pwr = dxm_pkg::DXM_ACTIVE;
    endcase
    // address latched at the load edge
    if (lm_emr) begin
      s_nxt.emr_pend = lm_addr;
      s_nxt.pend_emr = 1'b1;
      s_nxt.mrd_cnt = 2'(`DXM_TMRD_CK);
      rsvd_hit = rsvd_upper ||
                 (lm_addr[`DXM_E_AL_LSB +: 3] == `DXM_AL_RSVD);
      // calibration other than default or exit
      if (lm_addr[`DXM_E_OCD_LSB +: 3] != `DXM_OCD_DEFAULT &&
          lm_addr[`DXM_E_OCD_LSB +: 3] != 3'h0) begin
        rsvd_hit = 1'b1;
      end
      if (lm_addr[`DXM_E_RTT_HI] || lm_addr[`DXM_E_RTT_LO]) begin
        s_nxt.odt_cnt = 4'(`DXM_ODT_HOLD_CK);
      end
    end else if (lm_ext_mode_register_second) begin
      s_nxt.ext_mode_register_second_pend = lm_addr;
      s_nxt.pend_ext_mode_register_second = 1'b1;
      s_nxt.mrd_cnt = 2'(`DXM_TMRD_CK);
      // only bit 7 may be set
      rsvd_hit = rsvd_upper ||
                 ((lm_addr & ~(13'h1 << `DXM_E2_SRF)) != 13'h0);
    end else if (s_r.mrd_cnt != 2'h0) begin
      s_nxt.mrd_cnt = s_r.mrd_cnt - 2'h1;
    end
    if (!lm_emr && s_r.odt_cnt != 4'h0) begin
      s_nxt.odt_cnt = s_r.odt_cnt - 4'h1;
    end
    // settings switch after the mode-set delay
    // otherwise the applied settings never change
    if (apply && !lm_any) begin
      if (s_r.pend_emr) begin
        s_nxt.emr_cur = s_r.emr_pend;
      end
      if (s_r.pend_ext_mode_register_second) begin
        s_nxt.ext_mode_register_second_cur = s_r.ext_mode_register_second_pend;
      end
      s_nxt.pend_emr = 1'b0;
      s_nxt.pend_ext_mode_register_second = 1'b0;
    end
    // lock restarts on enable, reset or self refresh exit
    if (!dll_on || lm_mr_dll ||
        (s_r.pwr == dxm_pkg::DXM_SELF_REFRESH && wake)) begin
      s_nxt.lock_cnt = 8'h00;
      s_nxt.dll_locked = 1'b0;
    end else if (!s_r.dll_locked) begin
      s_nxt.lock_cnt = s_r.lock_cnt + 8'h01;
      if (s_r.lock_cnt == 8'(`DXM_DLL_LOCK_CK - 1)) begin
        s_nxt.dll_locked = 1'b1;
      end
    end
    s_nxt.rd_q = {s_r.rd_q[5:0], rd_cmd};
    s_nxt.wr_q = {s_r.wr_q[5:0], wr_cmd};
    // CAS latency and x8 width come from the control register
    if (wr_en && wr_dec == 3'h4 && wr_strb[0]) begin
      s_nxt.cl = wr_data[2:0];
      s_nxt.x8 = wr_data[3];
    end
    // Sticky flags: a new event wins over a clear in the same cycle
    if (wr_en && wr_dec == 3'h7 && wr_strb[1]) begin
      if (wr_data[`DXM_ST_ODT_EARLY]) begin
        s_nxt.odt_early = 1'b0;
      end
      if (wr_data[`DXM_ST_RSVD]) begin
        s_nxt.rsvd_err = 1'b0;
      end
    end
    if (odt_bad && rtt_on) begin
      s_nxt.odt_early = 1'b1;
    end
    if (rsvd_hit) begin
      s_nxt.rsvd_err = 1'b1;
    end
    s_nxt.out.dll_enable = dll_on;
    s_nxt.out.dll_locked = s_r.dll_locked;
    s_nxt.out.drive_reduced = s_r.emr_cur[`DXM_E_DRV_RED];
    s_nxt.out.dqs_n_enable = !s_r.emr_cur[`DXM_E_DQSN_OFF] &&
                             !s_r.emr_cur[`DXM_E_QOFF];
    // redundant strobe on x8 parts only
    s_nxt.out.redundant_read_strobe_enable = s_r.x8 && s_r.emr_cur[`DXM_E_REDUNDANT_READ_STROBE_EN] &&
                            !s_r.emr_cur[`DXM_E_QOFF];
    // complementary redundant strobe needs both bits
    s_nxt.out.redundant_read_strobe_n_enable = s_r.x8 && s_r.emr_cur[`DXM_E_REDUNDANT_READ_STROBE_EN] &&
                              !s_r.emr_cur[`DXM_E_DQSN_OFF] &&
                              !s_r.emr_cur[`DXM_E_QOFF];
    s_nxt.out.outputs_off = s_r.emr_cur[`DXM_E_QOFF];
    // termination value from bits 6 and 2
    s_nxt.out.rtt = dxm_pkg::dxm_rtt_t'({s_r.emr_cur[`DXM_E_RTT_HI],
                                         s_r.emr_cur[`DXM_E_RTT_LO]});
    // termination pin ignored in self refresh
    s_nxt.out.term_on = rtt_on && p.odt && !odt_bad &&
                        (s_r.pwr != dxm_pkg::DXM_SELF_REFRESH);
    s_nxt.out.add_lat = cur_al;
    s_nxt.out.read_lat = 4'({1'b0, cur_al}) + 4'({1'b0, s_r.cl});
    s_nxt.out.write_lat = s_nxt.out.read_lat - 4'h1;
    s_nxt.out.ocd_default = s_r.emr_cur[`DXM_E_OCD_LSB +: 3] ==
                            `DXM_OCD_DEFAULT;
    s_nxt.out.srf_fast = s_r.ext_mode_register_second_cur[`DXM_E2_SRF];
    // write: strobe ignored, only the internal command is issued
    s_nxt.out.int_read = int_rd;
    s_nxt.out.int_write = int_wr;
    s_nxt.out.settings_pending = s_nxt.pend_emr || s_nxt.pend_ext_mode_register_second;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.cke_q <= 1'b1;
      s_r.pwr <= dxm_pkg::DXM_ACTIVE;
      s_r.emr_cur <= `DXM_EMR_RST;
      s_r.cl <= `DXM_CL_RST;
      // Latencies match the reset CAS value from the first cycle on
      s_r.out.read_lat <= 4'(`DXM_CL_RST);
      s_r.out.write_lat <= 4'(`DXM_CL_RST - 1);
    end else begin
      s_r <= s_nxt;
    end
  end
  assign cfg = s_r.out;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_emr_route: assert property (
    lm_emr |=> s_r.emr_pend == $past(lm_addr))
    else $error("first register load not latched");
  a_ext_mode_register_second_route: assert property (
    lm_ext_mode_register_second |=> s_r.ext_mode_register_second_pend == $past(lm_addr) && s_r.pend_ext_mode_register_second)
    else $error("second register load not latched");
  a_apply_delay: assert property (
    lm_emr ##1 (!lm_any)[*2] |=> s_r.emr_cur == $past(lm_addr, 3))
    else $error("setting not applied after mode delay");
  a_hold_cfg: assert property (
    !(apply && s_r.pend_emr) |=> $stable(s_r.emr_cur))
    else $error("applied setting changed without load");
  a_dll_srf: assert property (
    s_r.pwr == dxm_pkg::DXM_SELF_REFRESH |=> !cfg.dll_enable)
    else $error("DLL enabled in self refresh");
  a_redundant_read_strobe_pair: assert property (
    cfg.redundant_read_strobe_n_enable |-> cfg.redundant_read_strobe_enable && cfg.dqs_n_enable)
    else $error("redundant complement without its pair");
  a_outputs_off: assert property (
    cfg.outputs_off |-> !cfg.dqs_n_enable && !cfg.redundant_read_strobe_enable)
    else $error("strobe enabled while outputs disabled");
  a_term_state: assert property (
    s_r.pwr == dxm_pkg::DXM_SELF_REFRESH |=> !cfg.term_on)
    else $error("termination on in self refresh");
  a_wl_rl: assert property (
    cfg.write_lat + 4'h1 == cfg.read_lat)
    else $error("write latency not read latency minus one");
  a_al_delay: assert property (
    rd_cmd && cur_al == 3'h2 |-> ##3 cfg.int_read)
    else $error("posted read not delayed by additive latency");
  a_dll_lock: assert property (
    $rose(s_r.dll_locked) |-> $past(s_r.lock_cnt) == 8'hc7)
    else $error("DLL lock before 200 clocks");
  a_odt_hold: assert property (
    cfg.term_on |-> $past(s_r.odt_cnt) == 4'h0)
    else $error("termination on during hold");
  c_emr_load: cover property (lm_emr ##3 !s_r.pend_emr);
  c_srf_cycle: cover property (sr_enter ##[1:50] wake);
  c_post_read: cover property (rd_cmd && cur_al != 3'h0);
  c_rsvd_flag: cover property ($rose(s_r.rsvd_err));
endmodule

/* dxm_defs.svh */
// Offsets, field positions, reset values and timing counts of the block
`ifndef DXM_DEFS_SVH
`define DXM_DEFS_SVH
`define DXM_CLK_PERIOD_NS 25
`define DXM_TMRD_CK       2
`define DXM_DLL_LOCK_CK   200
`define DXM_ODT_HOLD_CK   8
`define DXM_REG_CTRL      8'h00
`define DXM_REG_EMR       8'h04
`define DXM_REG_EXT_MODE_REGISTER_SECOND      8'h08
`define DXM_REG_STATUS    8'h0c
`define DXM_CL_RST        3'h3
`define DXM_EMR_RST       13'h0000
`define DXM_PINS_RST      25'h1f0_0000
`define DXM_E_DLL_OFF     0
`define DXM_E_DRV_RED     1
`define DXM_E_RTT_LO      2
`define DXM_E_AL_LSB      3
`define DXM_E_RTT_HI      6
`define DXM_E_OCD_LSB     7
`define DXM_E_DQSN_OFF    10
`define DXM_E_REDUNDANT_READ_STROBE_EN     11
`define DXM_E_QOFF        12
`define DXM_E2_SRF        7
`define DXM_AL_RSVD       3'h7
`define DXM_OCD_DEFAULT   3'h7
`define DXM_BA_MR         2'h0
`define DXM_BA_EMR        2'h1
`define DXM_BA_EXT_MODE_REGISTER_SECOND       2'h2
`define DXM_MR_DLL_RST    8
`define DXM_ST_ODT_EARLY  8
`define DXM_ST_RSVD       9
`define DXM_RESP_OKAY     2'h0
`define DXM_RESP_SLVERR   2'h2
`endif

/* dxm_pkg.sv */
// Types shared by the extended mode configuration block
package dxm_pkg;
  typedef enum logic [1:0] {DXM_RTT_OFF, DXM_RTT_75, DXM_RTT_150,
                            DXM_RTT_50} dxm_rtt_t;
  typedef enum logic [1:0] {DXM_ACTIVE, DXM_POWER_DOWN,
                            DXM_SELF_REFRESH} dxm_pwr_t;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } dxm_axil_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dxm_axil_resp_t;
  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [15:0] addr;
    logic        odt;
  } dxm_cmd_pins_t;
  typedef struct packed {
    logic        dll_enable;
    logic        dll_locked;
    logic        drive_reduced;
    logic        dqs_n_enable;
    logic        redundant_read_strobe_enable;
    logic        redundant_read_strobe_n_enable;
    logic        outputs_off;
    dxm_rtt_t    rtt;
    logic        term_on;
    logic [2:0]  add_lat;
    logic [3:0]  read_lat;
    logic [3:0]  write_lat;
    logic        ocd_default;
    logic        srf_fast;
    logic        int_read;
    logic        int_write;
    logic        settings_pending;
  } dxm_cfg_out_t;
endpackage

/* dxm_pin_sync.sv */
// Two-stage synchroniser for the command pins
module dxm_pin_sync #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dxm_sync_t;
  dxm_sync_t s_r;
  dxm_sync_t s_nxt;
  // First stage feeds only the second stage
  always_comb begin
    s_nxt.s1 = din;
    s_nxt.s2 = s_r.s1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= {RST, RST};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign dout = s_r.s2;
endmodule

/* dxm_axil_slave.sv */
// AXI4-Lite slave handshake for the configuration registers
`include "dxm_defs.svh"
module dxm_axil_slave (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  dxm_pkg::dxm_axil_req_t  req,
  output dxm_pkg::dxm_axil_resp_t resp,
  output logic                    wr_en,
  output logic [7:0]              wr_addr,
  output logic [31:0]             wr_data,
  output logic [3:0]              wr_strb,
  input  wire logic               wr_ok,
  input  wire logic [31:0]        rd_data,
  input  wire logic               rd_ok
);
  typedef struct packed {
    logic                    aw_have;
    logic                    w_have;
    logic [7:0]              awaddr;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    dxm_pkg::dxm_axil_resp_t r;
  } dxm_axs_t;
  dxm_axs_t s_r;
  dxm_axs_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    wr_en = s_r.aw_have && s_r.w_have && !s_r.r.bvalid;
    if (req.awvalid && s_r.r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr = req.awaddr;
    end
    if (req.wvalid && s_r.r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata = req.wdata;
      s_nxt.wstrb = req.wstrb;
    end
    if (wr_en) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.r.bvalid = 1'b1;
      s_nxt.r.bresp = wr_ok ? `DXM_RESP_OKAY : `DXM_RESP_SLVERR;
    end else if (s_r.r.bvalid && req.bready) begin
      s_nxt.r.bvalid = 1'b0;
    end
    if (req.arvalid && s_r.r.arready) begin
      s_nxt.r.rvalid = 1'b1;
      s_nxt.r.rdata = rd_ok ? rd_data : 32'h0000_0000;
      s_nxt.r.rresp = rd_ok ? `DXM_RESP_OKAY : `DXM_RESP_SLVERR;
    end else if (s_r.r.rvalid && req.rready) begin
      s_nxt.r.rvalid = 1'b0;
    end
    // Ready held in flops so the ports come straight from registers
    s_nxt.r.awready = !s_nxt.aw_have && !s_nxt.r.bvalid;
    s_nxt.r.wready = !s_nxt.w_have && !s_nxt.r.bvalid;
    s_nxt.r.arready = !s_nxt.r.rvalid;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign resp = s_r.r;
  assign wr_addr = s_r.awaddr;
  assign wr_data = s_r.wdata;
  assign wr_strb = s_r.wstrb;
endmodule

/* dxm_ctl_model.sv */
// Behavioural memory controller driving the command pins
module dxm_ctl_model (
  input  wire logic              aclk,
  output dxm_pkg::dxm_cmd_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 1'b0;
  initial pins = {5'h1f, 3'h0, 16'h0, 1'b0};
  // Idle address toggles so a stale load value is never mistaken
  always @(posedge aclk) begin
    if (!busy) pins.addr <= ~pins.addr;
  end
  // reserved bank bit and high bits zero
  task automatic load(input logic [1:0] b, input logic [12:0] e,
                      input int n);
    busy = 1'b1;
    @(posedge aclk);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h0;
    pins.ba <= {1'b0, b};
    pins.addr <= {3'h0, e};
    @(posedge aclk);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'hf;
    // mode-set wait, termination pin left as it was
    repeat (n) @(posedge aclk);
    busy = 1'b0;
  endtask
  // no auto refresh is issued, so no precharge-all is owed
  // read command held for one clock
  task automatic rd();
    busy = 1'b1;
    @(posedge aclk);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'h5;
    @(posedge aclk);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'hf;
    busy = 1'b0;
  endtask
  task automatic odt(input logic v);
    @(posedge aclk);
    pins.odt <= v;
  endtask
endmodule

/* dxm_ext_mode_config_test.sv */
// Self-checking bench for the extended mode register bank
module dxm_ext_mode_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    aclk = 1'b0;
  logic                    aresetn = 1'b0;
  dxm_pkg::dxm_axil_req_t  axi_req = '0;
  dxm_pkg::dxm_axil_resp_t axi_resp;
  dxm_pkg::dxm_cmd_pins_t  pins;
  dxm_pkg::dxm_cfg_out_t   cfg;
  int                      miscompares = 0;
  int                      samples_checked = 0;
  always #12.5 aclk = ~aclk;
  dxm_ext_mode_config uut (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .axi_req  (axi_req),
    .axi_resp (axi_resp),
    .pins     (pins),
    .cfg      (cfg)
  );
  dxm_ctl_model m (
    .aclk (aclk),
    .pins (pins)
  );
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, ta, tw;
    @(posedge aclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(negedge aclk);
      ta = aw && axi_resp.awready === 1'b1;
      tw = w && axi_resp.wready === 1'b1;
      @(posedge aclk);
      if (ta) axi_req.awvalid <= 1'b0;
      if (tw) axi_req.wvalid <= 1'b0;
      aw = aw && !ta;
      w = w && !tw;
    end
    do @(negedge aclk); while (axi_resp.bvalid !== 1'b1);
    @(posedge aclk);
    axi_req.bready <= 1'b0;
  endtask
  // Reads a word and compares both data and response code
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do @(negedge aclk); while (axi_resp.arready !== 1'b1);
    @(posedge aclk);
    axi_req.arvalid <= 1'b0;
    do @(negedge aclk); while (axi_resp.rvalid !== 1'b1);
    chk("rdata", e, axi_resp.rdata);
    chk("rresp", {30'h0, er}, {30'h0, axi_resp.rresp});
    @(posedge aclk);
    axi_req.rready <= 1'b0;
  endtask
  task automatic results();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    miscompares++;
    results();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rc(8'h00, 32'h3, 2'h0);
    rc(8'h04, 32'h0, 2'h0);
    chk("dll", 32'h1, cfg.dll_enable);
    rc(8'h40, 32'h0, 2'h2);
    wr(8'h00, 32'hd);
    rc(8'h00, 32'hd, 2'h0);
    m.load(2'h1, 13'h039e, 0);
    chk("early", 32'h0, cfg.drive_reduced);
    repeat (8) @(posedge aclk);
    chk("drv", 32'h1, cfg.drive_reduced);
    chk("rtt", 32'h1, cfg.rtt);
    chk("al", 32'h3, cfg.add_lat);
    chk("rl", 32'h8, cfg.read_lat);
    chk("wl", 32'h7, cfg.write_lat);
    chk("ocd", 32'h1, cfg.ocd_default);
    rc(8'h04, 32'h039e, 2'h0);
    m.load(2'h1, 13'h0046, 8);
    chk("ocd", 32'h0, cfg.ocd_default);
    chk("rtt", 32'h3, cfg.rtt);
    chk("rl", 32'h5, cfg.read_lat);
    m.odt(1'b1);
    repeat (5) @(posedge aclk);
    chk("term", 32'h1, cfg.term_on);
    m.odt(1'b0);
    for (int i = 0; i < 4; i++) begin
      m.load(2'h1, {1'b0, i[1], i[0], 10'h0}, 8);
      chk("dqsn", {31'h0, !i[0]}, cfg.dqs_n_enable);
      chk("redundant_read_strobe", {31'h0, i[1]}, cfg.redundant_read_strobe_enable);
      chk("rdqsn", {31'h0, i[1] & !i[0]}, cfg.redundant_read_strobe_n_enable);
    end
    m.load(2'h1, 13'h1001, 8);
    chk("qoff", 32'h1, cfg.outputs_off);
    chk("dll", 32'h0, cfg.dll_enable);
    m.load(2'h2, 13'h0080, 8);
    chk("srf", 32'h1, cfg.srf_fast);
    rc(8'h08, 32'h0080, 2'h0);
    rc(8'h04, 32'h1001, 2'h0);
    m.load(2'h1, 13'h0010, 8);
    m.load(2'h0, 13'h0100, 8);
    chk("lock", 32'h0, cfg.dll_locked);
    repeat (200) @(posedge aclk);
    chk("lock", 32'h1, cfg.dll_locked);
    m.rd();
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk("rd", 32'h1, cfg.int_read);
    @(negedge aclk);
    chk("rd", 32'h0, cfg.int_read);
    rc(8'h0c, 32'h3, 2'h0);
    results();
  end
endmodule
